//--- rtl/eps_cfg.svh
/*
 * Constants of the energy pulse and calibration scaling block: register
 * offsets, field widths, reset values and fixed scaling shifts.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef EPS_CFG_SVH
`define EPS_CFG_SVH

`define EPS_OFS_GAIN 8'h00
`define EPS_OFS_NUM 8'h04
`define EPS_OFS_DEN 8'h08
`define EPS_OFS_DIV 8'h0C
`define EPS_OFS_ENERGY 8'h10
`define EPS_OFS_LINE_ACT 8'h14
`define EPS_OFS_LINE_APP 8'h18
`define EPS_OFS_HALF_CYC 8'h1C
`define EPS_OFS_PERIOD 8'h20
`define EPS_OFS_STATUS 8'h24
`define EPS_OFS_MASK 8'h28

`define EPS_GAIN_W 12
`define EPS_RATIO_W 12
`define EPS_DIV_W 8
`define EPS_HALF_W 16
`define EPS_PERIOD_W 16
`define EPS_STAT_W 2
`define EPS_STAT_LINE_DONE 0
`define EPS_STAT_PULSE 1

`define EPS_GAIN_SHIFT 12
`define EPS_ENERGY_LSB 24
`define EPS_LINE_LSB 12
`define EPS_PERIOD_TICK 8
`define EPS_CF_UNIT_SHIFT 12
`define EPS_PULSE_CYCLES 16

`define EPS_GAIN_RESET 12'h000
`define EPS_RATIO_RESET 12'h03F
`define EPS_DIV_RESET 8'h00
`define EPS_HALF_RESET 16'h00C8
`define EPS_MASK_RESET 2'h0

`endif

//--- rtl/eps_pkg.sv
/*
 * Types of the energy pulse and calibration scaling block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package eps_pkg;
    typedef enum logic [0:0] {
        LINE_ARM,
        LINE_RUN
    } eps_line_state_type;
endpackage : eps_pkg

//--- rtl/eps_sync.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes a level from outside the clock domain.
 */
`timescale 1ns/1ns
`default_nettype none
module eps_sync (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // signal
    input wire logic async_in,
    output logic level_out
);
    logic stage1;
    logic stage2;
    logic stage3;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end
        else
        begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // change accepted once stages two and three agree
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            level_out <= 1'b0;
        else if (stage2 == stage3)
            level_out <= stage3;
    end
endmodule : eps_sync
`default_nettype wire

//--- rtl/eps_rate_mult.sv
/*
 * Rational rate multiplier turning gain-scaled active energy into pulses.
 * Assumes one sample at most per clock and positive power only counted.
 */
`timescale 1ns/1ns
`default_nettype none
module eps_rate_mult #(
    parameter int SAMPLE_W = 26,
    parameter int RATIO_W = 12,
    parameter int UNIT_SHIFT = 12
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // energy samples
    input wire logic sample_valid_in,
    input wire logic signed [SAMPLE_W-1:0] sample_in,
    // ratio settings
    input wire logic [RATIO_W-1:0] numerator_in,
    input wire logic [RATIO_W-1:0] denominator_in,
    // pulse
    output logic pulse_out
);
    localparam int ACC_W = SAMPLE_W + RATIO_W + UNIT_SHIFT + 2;

    initial
    begin
        if (UNIT_SHIFT < 0 || UNIT_SHIFT > 24 || SAMPLE_W < 2 || RATIO_W < 1)
            $error("eps_rate_mult: unsupported parameters");
    end

    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] inc;
    logic [ACC_W-1:0] thr;
    logic [ACC_W-1:0] sum;
    logic [RATIO_W:0] num_p1;
    logic [RATIO_W:0] den_p1;

    always_comb
    begin
        num_p1 = {1'b0, numerator_in} + 1'b1;
        den_p1 = {1'b0, denominator_in} + 1'b1;
        inc = '0;
        if (sample_valid_in && !sample_in[SAMPLE_W-1])
            inc = ACC_W'(sample_in) * ACC_W'(num_p1);
        thr = ACC_W'(den_p1) << UNIT_SHIFT;
        sum = acc + inc;
    end

    // remainder carried over each pulse
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            acc <= '0;
            pulse_out <= 1'b0;
        end
        else if (sum >= thr)
        begin
            acc <= sum - thr;
            pulse_out <= 1'b1;
        end
        else
        begin
            acc <= sum;
            pulse_out <= 1'b0;
        end
    end
endmodule : eps_rate_mult
`default_nettype wire

//--- rtl/eps_top.sv
/*
 * Energy pulse and calibration scaling: gain, energy divider, pulse
 * output, period measurement and line cycle accumulation, with registers.
 * Assumes power samples on the core clock and a zero-crossing pin level.
 */
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "eps_cfg.svh"
module eps_top #(
    parameter int PULSE_CYCLES = `EPS_PULSE_CYCLES,
    parameter int CF_UNIT_SHIFT = `EPS_CF_UNIT_SHIFT
) (
    // clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    // register port
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [31:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [31:0] REG_RDATA_OUT,
    // power samples
    input wire logic signed [23:0] ACTIVE_POWER_IN,
    input wire logic [23:0] APPARENT_POWER_IN,
    input wire logic POWER_VALID_IN,
    // line
    input wire logic ZERO_CROSS_IN,
    // outputs
    output logic ENERGY_PULSE_OUT,
    output logic IRQ_N_OUT
);
    initial
    begin
        if (PULSE_CYCLES < 1 || PULSE_CYCLES > 65535)
            $error("eps_top: PULSE_CYCLES out of range");
    end
    logic signed [`EPS_GAIN_W-1:0] active_power_gain;
    logic [`EPS_RATIO_W-1:0] pulse_ratio_numerator;
    logic [`EPS_RATIO_W-1:0] pulse_ratio_denominator;
    logic [`EPS_DIV_W-1:0] active_energy_divider;
    logic [`EPS_HALF_W-1:0] half_cycle_count;
    logic [`EPS_STAT_W-1:0] irq_mask;
    logic [`EPS_STAT_W-1:0] irq_status;
    logic signed [23:0] active_energy_accum;
    logic signed [23:0] line_active_energy;
    logic [23:0] line_apparent_energy;
    logic [`EPS_PERIOD_W-1:0] line_period;

    logic wr_gain;
    logic wr_num;
    logic wr_den;
    logic wr_div;
    logic wr_half;
    logic wr_mask;
    logic rd_status;

    // register write decode
    always_comb
    begin
        wr_gain = 1'b0;
        wr_num = 1'b0;
        wr_den = 1'b0;
        wr_div = 1'b0;
        wr_half = 1'b0;
        wr_mask = 1'b0;
        if (REG_WR_IN && REG_ADDR_IN == `EPS_OFS_GAIN)
            wr_gain = 1'b1;
        else if (REG_WR_IN && REG_ADDR_IN == `EPS_OFS_NUM)
            wr_num = 1'b1;
        else if (REG_WR_IN && REG_ADDR_IN == `EPS_OFS_DEN)
            wr_den = 1'b1;
        else if (REG_WR_IN && REG_ADDR_IN == `EPS_OFS_DIV)
            wr_div = 1'b1;
        else if (REG_WR_IN && REG_ADDR_IN == `EPS_OFS_HALF_CYC)
            wr_half = 1'b1;
        else if (REG_WR_IN && REG_ADDR_IN == `EPS_OFS_MASK)
            wr_mask = 1'b1;
        rd_status = REG_RD_IN && REG_ADDR_IN == `EPS_OFS_STATUS;
    end

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            active_power_gain <= `EPS_GAIN_RESET;
            pulse_ratio_numerator <= `EPS_RATIO_RESET;
            pulse_ratio_denominator <= `EPS_RATIO_RESET;
            active_energy_divider <= `EPS_DIV_RESET;
            half_cycle_count <= `EPS_HALF_RESET;
            irq_mask <= `EPS_MASK_RESET;
        end
        else
        begin
            if (wr_gain)
                active_power_gain <= REG_WDATA_IN[`EPS_GAIN_W-1:0];
            if (wr_num)
                pulse_ratio_numerator <= REG_WDATA_IN[`EPS_RATIO_W-1:0];
            if (wr_den)
                pulse_ratio_denominator <= REG_WDATA_IN[`EPS_RATIO_W-1:0];
            if (wr_div)
                active_energy_divider <= REG_WDATA_IN[`EPS_DIV_W-1:0];
            if (wr_half)
                half_cycle_count <= REG_WDATA_IN[`EPS_HALF_W-1:0];
            if (wr_mask)
                irq_mask <= REG_WDATA_IN[`EPS_STAT_W-1:0];
        end
    end

    // gain: p * (1 + gain / 4096)
    logic signed [35:0] gain_product;
    logic signed [25:0] scaled_power;
    always_comb
    begin
        gain_product = ACTIVE_POWER_IN * active_power_gain;
        scaled_power = {{2{ACTIVE_POWER_IN[23]}}, ACTIVE_POWER_IN}
            + {{2{gain_product[35]}}, gain_product[35:`EPS_GAIN_SHIFT]};
    end

    // readable energy, divided by the energy divider only
    logic signed [47:0] div_acc;
    logic signed [47:0] div_sum;
    logic signed [47:0] div_thr;
    logic [`EPS_DIV_W-1:0] div_eff;
    always_comb
    begin
        div_eff = (active_energy_divider == '0) ? `EPS_DIV_W'(1) : active_energy_divider;
        div_thr = 48'(div_eff) <<< `EPS_ENERGY_LSB;
        div_sum = div_acc;
        if (POWER_VALID_IN)
            div_sum = div_acc + 48'(scaled_power);
    end
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            div_acc <= '0;
            active_energy_accum <= '0;
        end
        else if (div_sum >= div_thr)
        begin
            div_acc <= div_sum - div_thr;
            active_energy_accum <= active_energy_accum + 24'sd1;
        end
        else if (div_sum <= -div_thr)
        begin
            div_acc <= div_sum + div_thr;
            active_energy_accum <= active_energy_accum - 24'sd1;
        end
        else
            div_acc <= div_sum;
    end

    // pulse chain sees gain-scaled energy, never the divider
    logic pulse_event;
    eps_rate_mult #(
        .SAMPLE_W(26),
        .RATIO_W(`EPS_RATIO_W),
        .UNIT_SHIFT(CF_UNIT_SHIFT)
    ) u_rate_mult (
        .clk_in(CORE_CLK_IN),
        .rst_in(RST_IN),
        .sample_valid_in(POWER_VALID_IN),
        .sample_in(scaled_power),
        .numerator_in(pulse_ratio_numerator),
        .denominator_in(pulse_ratio_denominator),
        .pulse_out(pulse_event)
    );

    logic [15:0] pulse_timer;
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
            pulse_timer <= '0;
        else if (pulse_event)
            pulse_timer <= 16'(PULSE_CYCLES);
        else if (pulse_timer != '0)
            pulse_timer <= pulse_timer - 16'd1;
    end
    assign ENERGY_PULSE_OUT = (pulse_timer != '0);
    // zero crossing and period
    logic zx_level;
    logic zx_prev;
    logic zx_edge;
    logic zx_rise;
    eps_sync u_zx_sync (
        .clk_in(CORE_CLK_IN),
        .rst_in(RST_IN),
        .async_in(ZERO_CROSS_IN),
        .level_out(zx_level)
    );
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
            zx_prev <= 1'b0;
        else
            zx_prev <= zx_level;
    end
    assign zx_edge = zx_level != zx_prev;
    assign zx_rise = zx_level && !zx_prev;

    logic [2:0] tick_div;
    logic tick8;
    logic [`EPS_PERIOD_W-1:0] period_cnt;
    assign tick8 = (tick_div == 3'(`EPS_PERIOD_TICK - 1));
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
            tick_div <= '0;
        else if (zx_rise || tick8)
            tick_div <= '0;
        else
            tick_div <= tick_div + 3'd1;
    end

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            period_cnt <= '0;
            line_period <= '0;
        end
        else if (zx_rise)
        begin
            line_period <= period_cnt + `EPS_PERIOD_W'(tick8 && period_cnt != '1);
            period_cnt <= '0;
        end
        else if (tick8 && period_cnt != '1)
            period_cnt <= period_cnt + `EPS_PERIOD_W'(1);
    end

    // line cycle accumulation over whole half cycles
    eps_pkg::eps_line_state_type line_state;
    logic [`EPS_HALF_W-1:0] half_seen;
    logic [`EPS_HALF_W-1:0] half_target;
    logic signed [47:0] line_act_acc;
    logic [47:0] line_app_acc;
    logic signed [47:0] next_line_act;
    logic [47:0] next_line_app;
    logic line_done;
    always_comb
    begin
        half_target = (half_cycle_count == '0) ? `EPS_HALF_W'(1) : half_cycle_count;
        next_line_act = line_act_acc;
        next_line_app = line_app_acc;
        if (POWER_VALID_IN)
        begin
            next_line_act = line_act_acc + 48'(scaled_power);
            next_line_app = line_app_acc + 48'(APPARENT_POWER_IN);
        end
        line_done = (line_state == eps_pkg::LINE_RUN) && zx_edge
            && (half_seen + `EPS_HALF_W'(1) >= half_target);
    end

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            line_state <= eps_pkg::LINE_ARM;
            half_seen <= '0;
            line_act_acc <= '0;
            line_app_acc <= '0;
        end
        else if (wr_half)
        begin
            line_state <= eps_pkg::LINE_ARM;
            half_seen <= '0;
        end
        else
        begin
            case (line_state)
                eps_pkg::LINE_ARM:
                begin
                    if (zx_edge)
                    begin
                        line_state <= eps_pkg::LINE_RUN;
                        half_seen <= '0;
                        line_act_acc <= '0;
                        line_app_acc <= '0;
                    end
                end
                eps_pkg::LINE_RUN:
                begin
                    if (line_done)
                    begin
                        half_seen <= '0;
                        line_act_acc <= '0;
                        line_app_acc <= '0;
                    end
                    else
                    begin
                        if (zx_edge)
                            half_seen <= half_seen + `EPS_HALF_W'(1);
                        line_act_acc <= next_line_act;
                        line_app_acc <= next_line_app;
                    end
                end
                default:
                    line_state <= eps_pkg::LINE_ARM;
            endcase
        end
    end

    // both results latched together so the host may read them in turn
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            line_active_energy <= '0;
            line_apparent_energy <= '0;
        end
        else if (line_done)
        begin
            line_active_energy <= next_line_act[`EPS_LINE_LSB+23:`EPS_LINE_LSB];
            line_apparent_energy <= next_line_app[`EPS_LINE_LSB+23:`EPS_LINE_LSB];
        end
    end

    // interrupt status: read clears, new event wins
    logic [`EPS_STAT_W-1:0] events;
    always_comb
    begin
        events = '0;
        events[`EPS_STAT_LINE_DONE] = line_done;
        events[`EPS_STAT_PULSE] = pulse_event;
    end
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
            irq_status <= '0;
        else if (rd_status)
            irq_status <= events;
        else
            irq_status <= irq_status | events;
    end
    assign IRQ_N_OUT = !(|(irq_status & irq_mask));

    // read data, valid only in the cycle after the strobe
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
            REG_RDATA_OUT <= '0;
        else if (!REG_RD_IN)
            REG_RDATA_OUT <= '0;
        else if (REG_ADDR_IN == `EPS_OFS_GAIN)
            REG_RDATA_OUT <= 32'(unsigned'(active_power_gain));
        else if (REG_ADDR_IN == `EPS_OFS_NUM)
            REG_RDATA_OUT <= 32'(pulse_ratio_numerator);
        else if (REG_ADDR_IN == `EPS_OFS_DEN)
            REG_RDATA_OUT <= 32'(pulse_ratio_denominator);
        else if (REG_ADDR_IN == `EPS_OFS_DIV)
            REG_RDATA_OUT <= 32'(active_energy_divider);
        else if (REG_ADDR_IN == `EPS_OFS_ENERGY)
            REG_RDATA_OUT <= 32'(unsigned'(active_energy_accum));
        else if (REG_ADDR_IN == `EPS_OFS_LINE_ACT)
            REG_RDATA_OUT <= 32'(unsigned'(line_active_energy));
        else if (REG_ADDR_IN == `EPS_OFS_LINE_APP)
            REG_RDATA_OUT <= 32'(line_apparent_energy);
        else if (REG_ADDR_IN == `EPS_OFS_HALF_CYC)
            REG_RDATA_OUT <= 32'(half_cycle_count);
        else if (REG_ADDR_IN == `EPS_OFS_PERIOD)
            REG_RDATA_OUT <= 32'(line_period);
        else if (REG_ADDR_IN == `EPS_OFS_STATUS)
            REG_RDATA_OUT <= 32'(irq_status);
        else if (REG_ADDR_IN == `EPS_OFS_MASK)
            REG_RDATA_OUT <= 32'(irq_mask);
        else
            REG_RDATA_OUT <= '0;
    end
endmodule : eps_top
`default_nettype wire

//--- verif/eps_chk.sv
/*
 * Port checker of the energy pulse block.
 * Assumes a bind into eps_top; one clock domain.
 */
`timescale 1ns/1ns
`default_nettype none
`include "eps_cfg.svh"
module eps_chk #(
    parameter int PULSE_CYCLES = 16
) (
    // clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    // register port
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [31:0] REG_RDATA_OUT,
    // outputs
    input wire logic ENERGY_PULSE_OUT,
    input wire logic IRQ_N_OUT
);
    int hi_cnt;
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);

    // length of the current high run of the pulse output
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
        if (RST_IN) hi_cnt <= 0;
        else if (ENERGY_PULSE_OUT) hi_cnt <= hi_cnt + 1;
        else hi_cnt <= 0;

    a_reset_quiet: assert property (
        $past(RST_IN) |-> IRQ_N_OUT && !ENERGY_PULSE_OUT && REG_RDATA_OUT == 32'h0)
        else $error("outputs active right after reset");
    a_irq_release: assert property (
        $rose(IRQ_N_OUT) |-> $past(REG_RD_IN && REG_ADDR_IN == `EPS_OFS_STATUS)
            || $past(REG_WR_IN && REG_ADDR_IN == `EPS_OFS_MASK))
        else $error("interrupt released without status read or mask write");
    a_pulse_width: assert property (
        $fell(ENERGY_PULSE_OUT) |-> hi_cnt >= PULSE_CYCLES)
        else $error("pulse shorter than its length");
    a_gain_width: assert property (
        $past(REG_RD_IN && REG_ADDR_IN == `EPS_OFS_GAIN) |-> REG_RDATA_OUT[31:12] == 20'h0)
        else $error("gain read upper bits set");
    a_ratio_width: assert property (
        $past(REG_RD_IN && (REG_ADDR_IN == `EPS_OFS_NUM || REG_ADDR_IN == `EPS_OFS_DEN))
            |-> REG_RDATA_OUT[31:12] == 20'h0)
        else $error("ratio read upper bits set");
    a_energy_width: assert property (
        $past(REG_RD_IN && REG_ADDR_IN == `EPS_OFS_ENERGY) |-> REG_RDATA_OUT[31:24] == 8'h0)
        else $error("energy read upper bits set");
    a_half_width: assert property (
        $past(REG_RD_IN && REG_ADDR_IN == `EPS_OFS_HALF_CYC) |-> REG_RDATA_OUT[31:16] == 16'h0)
        else $error("half cycle count wider than 16 bits");
    a_period_width: assert property (
        $past(REG_RD_IN && REG_ADDR_IN == `EPS_OFS_PERIOD) |-> REG_RDATA_OUT[31:16] == 16'h0)
        else $error("period wider than 16 bits");
    a_status_width: assert property (
        $past(REG_RD_IN && REG_ADDR_IN == `EPS_OFS_STATUS) |-> REG_RDATA_OUT[31:2] == 30'h0)
        else $error("status read upper bits set");
endmodule : eps_chk

bind eps_top eps_chk #(.PULSE_CYCLES(PULSE_CYCLES)) u_eps_chk (
    .CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .REG_ADDR_IN(REG_ADDR_IN),
    .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
    .ENERGY_PULSE_OUT(ENERGY_PULSE_OUT), .IRQ_N_OUT(IRQ_N_OUT));
`default_nettype wire

//--- verif/eps_line_src.sv
/*
 * Mains line model: zero-crossing level toggling each half period.
 * Assumes the core clock; the level freezes while disabled.
 */
`timescale 1ns/1ns
`default_nettype none
module eps_line_src #(
    parameter int HALF = 80
) (
    // clock
    input wire logic clk_in,
    // control
    input wire logic en_in,
    // line level
    output logic zc_out
);
    int cnt;
    initial zc_out = 1'b0;
    initial cnt = 0;
    // whole half cycles of fixed length
    always @(posedge clk_in)
        if (!en_in) cnt <= 0;
        else if (cnt == HALF - 1)
        begin
            cnt <= 0;
            zc_out <= ~zc_out;
        end
        else cnt <= cnt + 1;
endmodule : eps_line_src
`default_nettype wire

//--- verif/testbench.sv
/*
 * Self-checking bench of the energy pulse block.
 * Assumes short pulses and a small pulse unit for run time.
 */
`timescale 1ns/1ns
`default_nettype none
`include "eps_cfg.svh"
module testbench;
    logic clk, rst, wr, rd, valid, zc, pulse, irq_n, zc_en, pprev;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, d;
    logic signed [23:0] act;
    logic [23:0] app;
    int bad_count, compares, pcnt;

    eps_top #(.PULSE_CYCLES(4), .CF_UNIT_SHIFT(4)) uut (.CORE_CLK_IN(clk), .RST_IN(rst),
        .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
        .REG_RDATA_OUT(rdata), .ACTIVE_POWER_IN(act), .APPARENT_POWER_IN(app),
        .POWER_VALID_IN(valid), .ZERO_CROSS_IN(zc), .ENERGY_PULSE_OUT(pulse),
        .IRQ_N_OUT(irq_n));
    eps_line_src #(.HALF(80)) u_line (.clk_in(clk), .en_in(zc_en), .zc_out(zc));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk)
    begin
        pprev <= pulse;
        if (pulse && !pprev) pcnt <= pcnt + 1;
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task end_sim;
        $display("bad_count=%0d compares=%0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim

    task wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd_reg

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        rd_reg(a);
        chk(d, exp);
    endtask : rd_chk

    task smp(input logic signed [23:0] a, input logic [23:0] v, input int n);
        repeat (n)
        begin
            @(posedge clk);
            valid <= 1'b1;
            act <= a;
            app <= v;
            @(posedge clk);
            valid <= 1'b0;
            repeat (8) @(posedge clk);
        end
    endtask : smp

    task cf(input logic [11:0] g, input logic [11:0] nu, input logic [11:0] de,
            input logic signed [23:0] a, input logic [23:0] v, input int n);
        wr_reg(`EPS_OFS_GAIN, {20'h0, g});
        wr_reg(`EPS_OFS_NUM, {20'h0, nu});
        wr_reg(`EPS_OFS_DEN, {20'h0, de});
        pcnt = 0;
        smp(a, v, n);
        repeat (10) @(posedge clk);
    endtask : cf

    task rst_pulse;
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
    endtask : rst_pulse

    task t_regs;
        rd_chk(`EPS_OFS_GAIN, 32'h0);
        rd_chk(`EPS_OFS_DIV, 32'h0);
        rd_chk(`EPS_OFS_HALF_CYC, 32'hC8);
        wr_reg(8'h40, 32'hFFF);
        wr_reg(`EPS_OFS_ENERGY, 32'h123);
        rd_chk(`EPS_OFS_NUM, 32'h3F);
        rd_chk(`EPS_OFS_DEN, 32'h3F);
        rd_chk(`EPS_OFS_ENERGY, 32'h0);
        wr_reg(`EPS_OFS_HALF_CYC, 32'hFFFF);
        rd_chk(`EPS_OFS_HALF_CYC, 32'hFFFF);
    endtask : t_regs

    task t_pulses;
        wr_reg(`EPS_OFS_MASK, 32'h2);
        cf(12'h0, 12'h0, 12'h0, 24'sd16, 24'h0, 4);
        chk(pcnt, 4);
        chk(irq_n, 0);
        rd_chk(`EPS_OFS_STATUS, 32'h2);
        chk(irq_n, 1);
        wr_reg(`EPS_OFS_MASK, 32'h0);
        cf(12'h0, 12'h1, 12'h0, 24'sd8, 24'h0, 4);
        chk(pcnt, 4);
        cf(12'h0, 12'h0, 12'h2, 24'sd16, 24'h0, 9);
        chk(pcnt, 3);
        cf(12'h800, 12'h0, 12'h0, 24'sd16, 24'h0, 8);
        chk(pcnt, 4);
        cf(12'h0, 12'h0, 12'h0, -24'sd16, 24'h0, 4);
        chk(pcnt, 0);
        cf(12'h0, 12'h0, 12'h0, 24'sd0, 24'hFFFFFF, 4);
        chk(pcnt, 0);
        wr_reg(`EPS_OFS_DIV, 32'h5);
        cf(12'h0, 12'h0, 12'h0, 24'sd16, 24'h0, 4);
        chk(pcnt, 4);
    endtask : t_pulses

    task t_line;
        int i;
        wr_reg(`EPS_OFS_DEN, 32'hFFF);
        wr_reg(`EPS_OFS_MASK, 32'h1);
        @(posedge clk);
        act <= 24'sd1600;
        app <= 24'd1500;
        valid <= 1'b1;
        wr_reg(`EPS_OFS_HALF_CYC, 32'h2);
        zc_en <= 1'b1;
        for (i = 0; i < 2000 && irq_n !== 1'b0; i++) @(posedge clk);
        if (irq_n !== 1'b0)
        begin
            bad_count++;
            end_sim;
        end
        valid <= 1'b0;
        zc_en <= 1'b0;
        rd_chk(`EPS_OFS_LINE_ACT, 32'd62);
        rd_chk(`EPS_OFS_LINE_APP, 32'd58);
        rd_reg(`EPS_OFS_PERIOD);
        chk(d, 32'(2 * 80 / `EPS_PERIOD_TICK));
        rd_reg(`EPS_OFS_STATUS);
        chk(d[0], 1);
        chk(irq_n, 1);
    endtask : t_line

    task t_energy;
        rst_pulse;
        wr_reg(`EPS_OFS_GAIN, 32'h7FF);
        smp(24'sh7FFFFF, 24'h0, 2);
        rd_chk(`EPS_OFS_ENERGY, 32'h1);
        wr_reg(`EPS_OFS_DIV, 32'h2);
        smp(24'sh7FFFFF, 24'h0, 3);
        rd_chk(`EPS_OFS_ENERGY, 32'h2);
        rst_pulse;
        smp(24'sh7FFFFF, 24'h0, 2);
        rd_chk(`EPS_OFS_ENERGY, 32'h0);
    endtask : t_energy

    initial
    begin
        rst = 1'b1;
        {wr, rd, valid, zc_en, pprev} = 5'h0;
        addr = 8'h0;
        wdata = 32'h0;
        act = 24'sh0;
        app = 24'h0;
        d = 32'h0;
        bad_count = 0;
        compares = 0;
        pcnt = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_pulses;
        t_line;
        t_energy;
        end_sim;
    end
endmodule : testbench
`default_nettype wire
